/* core/eep_regs.svh */
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH

// host register byte offsets
`define EEP_CTRL_OFS      4'h0
`define EEP_STAT_OFS      4'h4
`define EEP_DIV_OFS       4'h8

// control register fields
`define EEP_CTRL_DATA_LSB 0
`define EEP_CTRL_START    8
`define EEP_CTRL_STOP     9
`define EEP_CTRL_RECV     10
`define EEP_CTRL_NACK     11

// status register fields
`define EEP_STAT_BUSY     0
`define EEP_STAT_NACK     1
`define EEP_STAT_RX_LSB   8

// timing
`define EEP_SYS_CLK_KHZ   125000
`define EEP_SCL_KHZ       100
`define EEP_LINK_PERIOD_PS 15000
`define EEP_TWR_MS        6
`define EEP_SPIKE_STD_NS  100
`define EEP_SPIKE_FAST_NS 50

`endif

/* core/eep_pkg.sv */
package eep_pkg;

    localparam int EEP_ADDR_W = 13;
    localparam int EEP_TWR_W  = 19;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000,
        DEV_RX   = 3'b001,
        DEV_ACK  = 3'b010,
        DEV_TX   = 3'b011,
        DEV_MACK = 3'b100,
        DEV_BUSY = 3'b101
    } eep_dev_st_t;

    typedef enum logic [2:0] {
        HST_IDLE  = 3'b000,
        HST_START = 3'b001,
        HST_BIT   = 3'b010,
        HST_REL   = 3'b011,
        HST_STOP  = 3'b100
    } eep_host_st_t;

    typedef struct packed {
        logic [5:0]            sync1;
        logic [5:0]            sync2;
        logic [1:0]            filt;
        logic [1:0]            filt_d;
        logic [1:0][2:0]       fcnt;
        eep_dev_st_t           st;
        logic [3:0]            bit_cnt;
        logic [7:0]            shreg;
        logic [1:0]            role;
        logic [EEP_ADDR_W-1:0] addr;
        logic                  rd;
        logic                  dirty;
        logic                  sda_lvl;
        logic                  sda_oe;
        logic                  busy;
        logic [EEP_TWR_W-1:0]  twr_cnt;
    } eep_dev_regs_t;

    typedef struct packed {
        logic         sda_s1;
        logic         sda_s2;
        eep_host_st_t st;
        logic [1:0]   ph;
        logic [15:0]  qcnt;
        logic [15:0]  div;
        logic [3:0]   bit_cnt;
        logic [8:0]   sh;
        logic [11:0]  ctrl;
        logic         nack_seen;
        logic [7:0]   rx;
        logic         scl;
        logic         sda_lvl;
        logic         sda_oe;
        logic         wait_req;
        logic [31:0]  rdata;
    } eep_host_regs_t;

endpackage

/* core/eep_if.sv */
interface eep_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;

    // open-drain wire with pull-up: low if any enabled driver pulls low
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

    modport host (
        output scl,
        output sda_host_o,
        output sda_host_oe,
        input  sda
    );

    modport dev (
        input  scl,
        input  sda,
        output sda_dev_o,
        output sda_dev_oe
    );
endinterface

/* core/eep_dev.sv */
`include "eep_regs.svh"

// What this block does
// - program cycle ends within 6 ms after stop
// - busy: bus ignored, data released, no ack
// - reject line glitches below 100/50 ns
// - two array address bytes follow slave address
// - master frames transfers with start and stop
// - receiver pulls data low on ninth clock
// - receiver acks each byte, withholds to end
// - slave byte: type, select, direction bit
// - respond only when type field matches
// - respond only when select matches straps
// - direction bit 1 reads, 0 writes
// - first address byte high, second low
// - select bits only choose this device
// - missing ack ends the exchange
// - keep five low bits of high byte
// - write protect: no data ack, no program
// - master polls completion with write address
module eep_dev #(
    parameter int unsigned TWR_CYCLES =
        int'((`EEP_TWR_MS * 64'd1000000000) / `EEP_LINK_PERIOD_PS),
    parameter bit          FAST_MODE  = 1'b0,
    // arbitrary default, not a real class code
    parameter logic [3:0]  TYPE_CODE  = 4'h5
) (
    // link clock domain
    input  wire logic       link_clk,
    input  wire logic       arst_n,
    input  wire logic       link_ce,
    // two-wire bus
    eep_if.dev              bus,
    // straps and protection pins
    input  wire logic [2:0] select_strap_pins,
    input  wire logic       write_protect,
    // status
    output logic            prog_busy
);
    import eep_pkg::*;

    localparam logic [2:0] SPK_STD = 3'((`EEP_SPIKE_STD_NS * 1000 + `EEP_LINK_PERIOD_PS - 1)
                                        / `EEP_LINK_PERIOD_PS);
    localparam logic [2:0] SPK_FAST = 3'((`EEP_SPIKE_FAST_NS * 1000 + `EEP_LINK_PERIOD_PS - 1)
                                         / `EEP_LINK_PERIOD_PS);
    localparam logic [2:0] SPK = FAST_MODE ? SPK_FAST : SPK_STD;
    localparam logic [EEP_TWR_W-1:0] TWR_LOAD = EEP_TWR_W'(TWR_CYCLES - 1);
    localparam int unsigned MEM_DEPTH = 1 << EEP_ADDR_W;

    // idle bus lines are high, so reset the line samplers high
    localparam eep_dev_regs_t DEV_RST = '{
        sync1:  6'h03,
        sync2:  6'h03,
        filt:   2'h3,
        filt_d: 2'h3,
        st:     DEV_IDLE,
        default: '0
    };

    eep_dev_regs_t         r;
    eep_dev_regs_t         n;
    logic [7:0]            mem [0:MEM_DEPTH-1];
    logic                  mem_we;
    logic [7:0]            mem_rdata;

    assign mem_rdata = mem[r.addr];

    always_comb begin
        logic       scl_rise;
        logic       scl_fall;
        logic       start_c;
        logic       stop_c;
        logic       sda_v;
        logic [2:0] sel;
        logic       wp;
        scl_rise = r.filt[0] & ~r.filt_d[0];
        scl_fall = ~r.filt[0] & r.filt_d[0];
        start_c  = r.filt[0] & r.filt_d[0] & r.filt_d[1] & ~r.filt[1];
        stop_c   = r.filt[0] & r.filt_d[0] & ~r.filt_d[1] & r.filt[1];
        sda_v    = r.filt[1];
        sel      = r.sync2[4:2];
        wp       = r.sync2[5];
        n        = r;
        mem_we   = 1'b0;

        n.sync1  = {write_protect, select_strap_pins, bus.sda, bus.scl};
        n.sync2  = r.sync1;
        n.filt_d = r.filt;
        // a new level must persist SPK samples before it is believed
        for (int i = 0; i < 2; i++) begin
            if (r.sync2[i] == r.filt[i]) begin
                n.fcnt[i] = 3'h0;
            end else if (r.fcnt[i] == SPK - 3'h1) begin
                n.filt[i] = r.sync2[i];
                n.fcnt[i] = 3'h0;
            end else begin
                n.fcnt[i] = r.fcnt[i] + 3'h1;
            end
        end

        if (r.st == DEV_BUSY) begin
            // start, stop and bus bits are ignored while programming; the line filters keep sampling
            n.sda_oe = 1'b0;
            if (r.twr_cnt == '0) begin
                n.st   = DEV_IDLE;
                n.busy = 1'b0;
            end else begin
                n.twr_cnt = r.twr_cnt - 1'b1;
            end
        end else if (start_c) begin
            n.st      = DEV_RX;
            n.role    = 2'd0;
            n.bit_cnt = 4'h0;
            n.sda_oe  = 1'b0;
        end else if (stop_c) begin
            n.sda_oe = 1'b0;
            n.st     = DEV_IDLE;
            if (r.dirty) begin
                n.st      = DEV_BUSY;
                n.busy    = 1'b1;
                n.twr_cnt = TWR_LOAD;
                n.dirty   = 1'b0;
            end
        end else begin
            unique case (r.st)
                DEV_IDLE: begin
                end
                DEV_RX: begin
                    if (scl_rise) begin
                        n.shreg   = {r.shreg[6:0], sda_v};
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == 4'h8) begin
                        n.bit_cnt = 4'h0;
                        n.st      = DEV_ACK;
                        n.sda_oe  = 1'b1;
                        unique case (r.role)
                            2'd0: begin
                                // one page block only: select just picks this part
                                if (r.shreg[7:4] == TYPE_CODE &&
                                    r.shreg[3:1] == sel) begin
                                    n.rd   = r.shreg[0];
                                    n.role = 2'd1;
                                end else begin
                                    n.st     = DEV_IDLE;
                                    n.sda_oe = 1'b0;
                                end
                            end
                            2'd1: begin
                                n.addr[EEP_ADDR_W-1:8] = r.shreg[4:0];
                                n.role                 = 2'd2;
                            end
                            2'd2: begin
                                n.addr[7:0] = r.shreg;
                                n.role      = 2'd3;
                            end
                            2'd3: begin
                                if (wp) begin
                                    n.st     = DEV_IDLE;
                                    n.sda_oe = 1'b0;
                                end else begin
                                    mem_we    = 1'b1;
                                    n.dirty   = 1'b1;
                                    // page roll-over: only the low five bits advance
                                    n.addr[4:0] = r.addr[4:0] + 5'h1;
                                end
                            end
                        endcase
                    end
                end
                DEV_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        if (r.rd) begin
                            n.st      = DEV_TX;
                            n.shreg   = mem_rdata;
                            n.sda_oe  = ~mem_rdata[7];
                            n.addr    = r.addr + 1'b1;
                            n.bit_cnt = 4'h1;
                        end else begin
                            n.st = DEV_RX;
                        end
                    end
                end
                DEV_TX: begin
                    if (scl_fall) begin
                        if (r.bit_cnt == 4'h8) begin
                            n.sda_oe = 1'b0;
                            n.st     = DEV_MACK;
                        end else begin
                            n.shreg   = {r.shreg[6:0], 1'b0};
                            n.sda_oe  = ~r.shreg[6];
                            n.bit_cnt = r.bit_cnt + 4'h1;
                        end
                    end
                end
                DEV_MACK: begin
                    if (scl_rise) begin
                        // no ack from the master means it is done reading
                        n.st = sda_v ? DEV_IDLE : DEV_ACK;
                    end
                end
                DEV_BUSY: begin
                end
                default: begin
                    n.st     = DEV_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= DEV_RST;
        end else if (link_ce) begin
            r <= n;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_ce && mem_we) begin
            mem[r.addr] <= r.shreg;
        end
    end

    assign bus.sda_dev_o  = r.sda_lvl;
    assign bus.sda_dev_oe = r.sda_oe;
    assign prog_busy      = r.busy;
endmodule

/* core/eep_host.sv */
`include "eep_regs.svh"

module eep_host (
    // system
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        sys_ce,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // two-wire bus
    eep_if.host              bus
);
    import eep_pkg::*;

    // quarter of the scl period, rounded up so scl never runs fast
    localparam logic [15:0] DIV_RST = 16'((`EEP_SYS_CLK_KHZ + 4 * `EEP_SCL_KHZ - 1)
                                          / (4 * `EEP_SCL_KHZ));

    localparam eep_host_regs_t HOST_RST = '{
        sda_s1:   1'b1,
        sda_s2:   1'b1,
        st:       HST_IDLE,
        div:      DIV_RST,
        scl:      1'b1,
        wait_req: 1'b1,
        default:  '0
    };

    eep_host_regs_t r;
    eep_host_regs_t n;

    always_comb begin
        logic tick;
        logic sda_v;
        logic busy;
        tick  = (r.qcnt == 16'h0);
        sda_v = r.sda_s2;
        busy  = (r.st != HST_IDLE);
        n     = r;

        n.sda_s1   = bus.sda;
        n.sda_s2   = r.sda_s1;
        n.wait_req = 1'b1;

        if (busy) begin
            n.qcnt = tick ? r.div - 16'h1 : r.qcnt - 16'h1;
        end

        // bus answer; a command write stalls until the engine is idle
        if ((avs_read || avs_write) && r.wait_req &&
            !(avs_write && avs_address == `EEP_CTRL_OFS && busy)) begin
            n.wait_req = 1'b0;
            unique case (avs_address)
                `EEP_CTRL_OFS: n.rdata = {20'h0, r.ctrl};
                `EEP_STAT_OFS: n.rdata = {16'h0, r.rx, 6'h0, r.nack_seen, busy};
                `EEP_DIV_OFS:  n.rdata = {16'h0, r.div};
                default:       n.rdata = 32'h0;
            endcase
        end

        // writes land at the edge where the master sees waitrequest low
        if (avs_write && !r.wait_req && avs_address == `EEP_DIV_OFS) begin
            n.div = avs_writedata[15:0];
        end
        if (avs_write && !r.wait_req && avs_address == `EEP_CTRL_OFS) begin
            n.ctrl    = avs_writedata[11:0];
            n.ph      = 2'd0;
            n.qcnt    = r.div - 16'h1;
            n.bit_cnt = 4'h0;
            // receive: release data bits and drive our own ack bit
            n.sh = avs_writedata[`EEP_CTRL_RECV] ?
                   {8'hFF, avs_writedata[`EEP_CTRL_NACK]} :
                   {avs_writedata[7:0], 1'b1};
            n.st = avs_writedata[`EEP_CTRL_START] ? HST_START : HST_BIT;
        end

        if (busy && tick) begin
            n.ph = r.ph + 2'd1;
            unique case (r.st)
                HST_START: begin
                    unique case (r.ph)
                        2'd0: n.sda_oe = 1'b0;
                        2'd1: n.scl    = 1'b1;
                        2'd2: n.sda_oe = 1'b1;
                        2'd3: begin
                            n.scl = 1'b0;
                            n.st  = HST_BIT;
                        end
                    endcase
                end
                HST_BIT: begin
                    unique case (r.ph)
                        2'd0: n.sda_oe = ~r.sh[8];
                        2'd1: n.scl    = 1'b1;
                        2'd2: begin
                            n.sh = {r.sh[7:0], sda_v};
                            if (r.bit_cnt == 4'h8) begin
                                n.rx        = r.sh[7:0];
                                n.nack_seen = sda_v;
                            end
                        end
                        2'd3: begin
                            n.scl     = 1'b0;
                            n.bit_cnt = r.bit_cnt + 4'h1;
                            if (r.bit_cnt == 4'h8) begin
                                n.st = HST_REL;
                            end
                        end
                    endcase
                end
                HST_REL: begin
                    // release a quarter after scl falls, never together with it
                    n.sda_oe = 1'b0;
                    n.ph     = 2'd0;
                    n.st     = r.ctrl[`EEP_CTRL_STOP] ? HST_STOP : HST_IDLE;
                end
                HST_STOP: begin
                    unique case (r.ph)
                        2'd0: n.sda_oe = 1'b1;
                        2'd1: n.scl    = 1'b1;
                        2'd2: n.sda_oe = 1'b0;
                        2'd3: n.st     = HST_IDLE;
                    endcase
                end
                default: begin
                    n.st     = HST_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= HOST_RST;
        end else if (sys_ce) begin
            r <= n;
        end
    end

    assign avs_readdata    = r.rdata;
    assign avs_waitrequest = r.wait_req;
    assign bus.scl         = r.scl;
    assign bus.sda_host_o  = r.sda_lvl;
    assign bus.sda_host_oe = r.sda_oe;
endmodule

/* dv/eep_link_properties.sv */
module eep_link_properties #(
    parameter int TWR_CYCLES = 200
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic link_clk,
    input wire logic arst_n,
    // two-wire bus
    input wire logic scl,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda,
    // device status
    input wire logic prog_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned busy_cnt;
    int unsigned stop_age;
    logic        sda_q;
    logic        scl_q;

    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!arst_n);

    // stop seen on the raw pins; age saturates so it never wraps back to young
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= 0;
            stop_age <= 1000;
            sda_q    <= 1'b1;
            scl_q    <= 1'b1;
        end else begin
            sda_q    <= sda;
            scl_q    <= scl;
            busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
            if (scl && scl_q && sda && !sda_q) begin
                stop_age <= 0;
            end else if (stop_age < 1000) begin
                stop_age <= stop_age + 1;
            end
        end
    end

    a_busy_quiet: assert property (prog_busy |-> !sda_dev_oe)
        else $error("device drives data while programming");
    a_busy_max: assert property (busy_cnt <= TWR_CYCLES + 1)
        else $error("program cycle too long");
    a_busy_full: assert property ($fell(prog_busy) |-> busy_cnt >= TWR_CYCLES - 1)
        else $error("program cycle too short");
    a_busy_at_stop: assert property ($rose(prog_busy) |-> stop_age < 40)
        else $error("program cycle not started by stop");
    a_oe_rise_low: assert property ($rose(sda_dev_oe) |-> !scl)
        else $error("device grabs data while clock high");
    a_oe_fall_low: assert property ($fell(sda_dev_oe) |-> !scl)
        else $error("device lets go of data while clock high");
    a_ack_span: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
        else $error("device pulse too short");
    a_open_drain: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
        else $error("device drive does not pull the wire low");
    a_host_yields: assert property (sda_dev_oe && scl |-> !sda_host_oe)
        else $error("host drives while device holds data");
    a_scl_low_span: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");

    c_prog: cover property ($rose(prog_busy));
    c_dev_ack: cover property (sda_dev_oe && scl);
    c_host_ack: cover property (sda_host_oe && !sda_host_o && scl && !sda_dev_oe);
endmodule

/* dv/eeprom_two_byte_addr_i2c_slave_test.sv */
`include "eep_regs.svh"

module eeprom_two_byte_addr_i2c_slave_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         SELF_TIMED_PROGRAM_TIME   = 2000;
    localparam int         QDIV  = 40;
    // arbitrary type code, not a real class code
    localparam logic [3:0] DTYPE = 4'h5;
    localparam logic [2:0] STRAP = 3'b101;
    localparam logic [11:0] SLV_W = {4'h0, DTYPE, STRAP, 1'b0};
    localparam logic [11:0] F_S  = 12'h001 << `EEP_CTRL_START;
    localparam logic [11:0] F_P  = 12'h001 << `EEP_CTRL_STOP;
    localparam logic [11:0] F_R  = 12'h001 << `EEP_CTRL_RECV;
    localparam logic [11:0] F_N  = 12'h001 << `EEP_CTRL_NACK;

    logic        sys_clk;
    logic        link_clk;
    logic        arst_n;
    logic        write_protect;
    logic        prog_busy;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          errors;
    int          n_checks;
    logic [7:0]  bad [5] = '{8'hDA, 8'h4A, 8'h58, 8'h5E, 8'h52};

    eep_if bus ();

    eep_host u_eep_host (.sys_clk(sys_clk), .arst_n(arst_n), .sys_ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus(bus.host));

    eep_dev #(.TWR_CYCLES(SELF_TIMED_PROGRAM_TIME), .TYPE_CODE(DTYPE)) u_eep_dev (.link_clk(link_clk),
        .arst_n(arst_n), .link_ce(1'b1), .bus(bus.dev), .select_strap_pins(STRAP),
        .write_protect(write_protect), .prog_busy(prog_busy));

    eep_link_properties #(.TWR_CYCLES(SELF_TIMED_PROGRAM_TIME)) u_eep_link_properties (.sys_clk(sys_clk),
        .link_clk(link_clk), .arst_n(arst_n), .scl(bus.scl), .sda_host_o(bus.sda_host_o),
        .sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o),
        .sda_dev_oe(bus.sda_dev_oe), .sda(bus.sda), .prog_busy(prog_busy));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // free-running, phase unrelated to the system clock
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 5000);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 5000) chk("avalon answer", 32'h0, 32'h1);
    endtask

    // launch one byte, then poll status until the engine is idle again
    task automatic xbyte(input logic [11:0] c, output logic [31:0] st);
        int n;
        av_xfer(1'b1, `EEP_CTRL_OFS, {20'h0, c}, st);
        n = 0;
        do begin
            av_xfer(1'b0, `EEP_STAT_OFS, 32'h0, st);
            n++;
        end while (st[`EEP_STAT_BUSY] !== 1'b0 && n < 2000);
        if (n >= 2000) chk("engine idle", 32'h0, 32'h1);
    endtask

    task automatic tx(input logic [11:0] c, input logic nak, input string what);
        logic [31:0] st;
        xbyte(c, st);
        chk(what, {31'h0, nak}, {31'h0, st[`EEP_STAT_NACK]});
    endtask

    task automatic rd_at(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1,
                         input logic two);
        logic [31:0] st;
        tx(F_S | SLV_W, 1'b0, "rd slave w");
        tx({4'h0, a[15:8]}, 1'b0, "rd addr hi");
        tx({4'h0, a[7:0]}, 1'b0, "rd addr lo");
        tx(F_S | SLV_W | 12'h001, 1'b0, "rd slave r");
        xbyte(two ? F_R : (F_R | F_N | F_P), st);
        chk("rd byte 0", {24'h0, e0}, {24'h0, st[15:8]});
        if (two) begin
            xbyte(F_R | F_N | F_P, st);
            chk("rd byte 1", {24'h0, e1}, {24'h0, st[15:8]});
        end
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #750000;
        errors++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] q;
        int          polls;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        write_protect = 1'b0;
        errors = 0;
        n_checks = 0;
        repeat (2) @(posedge link_clk);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        // let the device filters settle before the first start
        repeat (20) @(posedge link_clk);
        av_xfer(1'b0, `EEP_DIV_OFS, 32'h0, q);
        chk("div reset", 32'h139, q);
        av_xfer(1'b1, `EEP_DIV_OFS, QDIV, q);
        av_xfer(1'b0, `EEP_DIV_OFS, 32'h0, q);
        chk("div", QDIV, q);
        av_xfer(1'b1, 4'hC, 32'hFFFF, q);
        av_xfer(1'b0, 4'hC, 32'h0, q);
        chk("unmapped", 32'h0, q);
        // page write from the last byte of a page, so the second byte rolls over
        tx(F_S | SLV_W, 1'b0, "wr slave");
        tx(12'h0E1, 1'b0, "wr addr hi");
        tx(12'h0FF, 1'b0, "wr addr lo");
        tx(12'h0A5, 1'b0, "wr data 0");
        tx(12'h03C, 1'b0, "wr data 1");
        tx(F_P | 12'h0C3, 1'b0, "wr data 2");
        tx(F_S | F_P | SLV_W, 1'b1, "poll while busy");
        polls = 0;
        do begin
            xbyte(F_S | F_P | SLV_W, q);
            polls++;
        end while (q[`EEP_STAT_NACK] !== 1'b0 && polls < 8);
        chk("poll done", 32'h0, {31'h0, q[`EEP_STAT_NACK]});
        rd_at(16'h01E0, 8'h3C, 8'hC3, 1'b1);
        foreach (bad[i]) begin
            tx(F_S | F_P | {4'h0, bad[i]}, 1'b1, "foreign slave");
        end
        write_protect <= 1'b1;
        tx(F_S | SLV_W, 1'b0, "wp slave");
        tx(12'h001, 1'b0, "wp addr hi");
        tx(12'h0FF, 1'b0, "wp addr lo");
        tx(F_P | 12'h05A, 1'b1, "wp data");
        tx(F_S | F_P | SLV_W, 1'b0, "wp no program");
        write_protect <= 1'b0;
        rd_at(16'hE1FF, 8'hA5, 8'h00, 1'b0);
        tally_and_finish();
    end
endmodule
